// File: common/psl_pkg.sv
// Operation
// - ready rises 7.5 clocks after byte capture
// - large variant: 40 clock startup to user
// - small variant: 10 clock startup to user
// - completion low within 200 ns of restart
// - error status low within 200 ns of restart
// - error status released soon after restart rises
// - error pulse 10-40 us large, 1 us small
// - oscillator startup 2-8 / 0.6-2 us
// - capture on rise, serialize on eight falls
// - ready/busy shows serializing or ready
// - configuration error drives error status low
package psl_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS          = 8;
    localparam int STAT_MIN_LG_NS  = 10000;
    localparam int STAT_MIN_SM_NS  = 1000;
    localparam int OSC_MIN_LG_NS   = 2000;
    localparam int OSC_MIN_SM_NS   = 600;
    localparam logic [11:0] STAT_LG_CYC = 12'((STAT_MIN_LG_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] STAT_SM_CYC = 12'((STAT_MIN_SM_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] OSC_LG_CYC  = 12'((OSC_MIN_LG_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] OSC_SM_CYC  = 12'((OSC_MIN_SM_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0]  START_LG_CLKS = 6'h28;
    localparam logic [5:0]  START_SM_CLKS = 6'h0a;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

    // ****************************************
    // startup clock source and states
    // ****************************************
    localparam logic [1:0] SRC_OSC  = 2'h0;
    localparam logic [1:0] SRC_USER = 2'h1;

    typedef enum logic [7:0] {
        ST_RESTART = 8'h01,
        ST_STATUS  = 8'h02,
        ST_WAITLN  = 8'h04,
        ST_LOAD    = 8'h08,
        ST_SETTLE  = 8'h10,
        ST_STARTUP = 8'h20,
        ST_USER    = 8'h40,
        ST_FAULT   = 8'h80
    } psl_state_e;
endpackage

// File: common/psl_ser_if.sv
`timescale 1ns/1ps
interface psl_ser_if;
    logic       loadStb;
    logic [7:0] loadByte;
    logic       fallStb;
    logic       clear;
    logic       bitOut;
    logic       bitValid;
    logic       busy;
    modport ctrl (output loadStb, loadByte, fallStb, clear, input bitOut, bitValid, busy);
    modport ser  (input loadStb, loadByte, fallStb, clear, output bitOut, bitValid, busy);
endinterface

// File: design/psl_config_load.sv
`timescale 1ns/1ps
module psl_config_load
    import psl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        configRestartN,
    input  wire logic        configClock,
    input  wire logic [7:0]  configData,
    input  wire logic        userStartupClock,
    input  wire logic [1:0]  startupSource,
    input  wire logic        largeVariant,
    input  wire logic [23:0] imageBytes,
    input  wire logic        frameError,
    input  wire logic        errorStatusNIn,
    output logic             errorStatusNOut,
    output logic             errorStatusNOeN,
    input  wire logic        configCompleteIn,
    output logic             configCompleteOut,
    output logic             configCompleteOeN,
    output logic             readyNotBusy,
    output logic             serialBit,
    output logic             serialValid,
    output logic             userMode
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic        rstS1;
        logic        rstS2;
        logic        clkS1;
        logic        clkS2;
        logic        clkPrev;
        logic [7:0]  dataS1;
        logic [7:0]  dataS2;
        logic        ucS1;
        logic        ucS2;
        logic        ucPrev;
        logic        errS1;
        logic        errS2;
        logic        cmpS1;
        logic        cmpS2;
        psl_state_e  state;
        logic [11:0] timer;
        logic [23:0] byteCnt;
        logic [5:0]  startCnt;
        logic        errDrive;
        logic        cmpDrive;
        logic        rdy;
        logic        user;
        logic        serBit;
        logic        serValid;
    } psl_top_s;

    psl_top_s r_reg;
    psl_top_s r_next;
    psl_ser_if sif ();

    logic        riseCk;
    logic        fallCk;
    logic        riseUc;
    logic        startTick;
    logic [11:0] pulseMin;
    logic [11:0] oscCyc;
    logic [5:0]  startLimit;

    // edges only from second sync stage and its delayed copy
    assign riseCk    = r_reg.clkS2 & ~r_reg.clkPrev;
    assign fallCk    = ~r_reg.clkS2 & r_reg.clkPrev;
    assign riseUc    = r_reg.ucS2 & ~r_reg.ucPrev;
    assign startTick = (startupSource == SRC_USER) ? riseUc : riseCk;
    // variant picks the figures; the strap must be stable before restart rises
    assign pulseMin   = largeVariant ? STAT_LG_CYC : STAT_SM_CYC;
    assign oscCyc     = largeVariant ? OSC_LG_CYC : OSC_SM_CYC;
    assign startLimit = largeVariant ? START_LG_CLKS : START_SM_CLKS;

    psl_serializer u_ser (
        .clk_sys (clk_sys),
        .rst     (rst),
        .sif     (sif.ser)
    );

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        r_next         = r_reg;
        r_next.rstS1   = configRestartN;
        r_next.rstS2   = r_reg.rstS1;
        r_next.clkS1   = configClock;
        r_next.clkS2   = r_reg.clkS1;
        r_next.clkPrev = r_reg.clkS2;
        r_next.dataS1  = configData;
        r_next.dataS2  = r_reg.dataS1;
        r_next.ucS1    = userStartupClock;
        r_next.ucS2    = r_reg.ucS1;
        r_next.ucPrev  = r_reg.ucS2;
        r_next.errS1   = errorStatusNIn;
        r_next.errS2   = r_reg.errS1;
        r_next.cmpS1   = configCompleteIn;
        r_next.cmpS2   = r_reg.cmpS1;
        r_next.serBit  = sif.bitOut;
        r_next.serValid = sif.bitValid;
        if (r_reg.timer != 12'hfff) begin
            r_next.timer = r_reg.timer + 12'h001; // saturates, no wrap
        end
        sif.loadStb  = 1'b0;
        sif.loadByte = r_reg.dataS2;
        sif.fallStb  = fallCk;
        sif.clear    = 1'b0;

        if (!r_reg.rstS2 && r_reg.state != ST_RESTART) begin
            // restart wins from any state; pull both lines low at once
            r_next.state    = ST_RESTART;
            r_next.timer    = 12'h000;
            r_next.errDrive = 1'b1;
            r_next.cmpDrive = 1'b1;
            r_next.rdy      = 1'b0;
            r_next.user     = 1'b0;
            sif.clear       = 1'b1;
        end else begin
            unique case (r_reg.state)
                ST_RESTART: begin
                    sif.clear        = 1'b1;
                    r_next.byteCnt   = 24'h000000;
                    r_next.startCnt  = 6'h00;
                    if (r_reg.rstS2) begin
                        r_next.state = ST_STATUS;
                    end
                end
                ST_STATUS: begin
                    // timer runs from the restart fall, so the pulse has its floor
                    if (r_reg.timer >= pulseMin) begin
                        r_next.errDrive = 1'b0;
                        r_next.state    = ST_WAITLN;
                    end
                end
                ST_WAITLN: begin
                    // host may stretch the line low; wait until it floats high
                    if (r_reg.errS2) begin
                        r_next.rdy   = 1'b1;
                        r_next.state = ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (frameError || !r_reg.errS2) begin
                        r_next.errDrive = 1'b1;
                        r_next.rdy      = 1'b0;
                        r_next.state    = ST_FAULT;
                    end else if (riseCk && !sif.busy && r_reg.byteCnt != imageBytes) begin
                        sif.loadStb    = 1'b1;
                        r_next.byteCnt = r_reg.byteCnt + 24'h000001;
                        r_next.rdy     = 1'b0;
                    end else if (sif.bitValid && !sif.busy) begin
                        // last shift is the eighth fall, 7.5 clocks after capture
                        r_next.rdy = 1'b1;
                    end else if (!sif.busy && r_reg.byteCnt == imageBytes) begin
                        r_next.cmpDrive = 1'b0;
                        r_next.state    = ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    // shared completion line: start only once every loader released it
                    if (r_reg.cmpS2) begin
                        r_next.timer    = 12'h000;
                        r_next.startCnt = 6'h00;
                        r_next.state    = ST_STARTUP;
                    end
                end
                ST_STARTUP: begin
                    if (startupSource == SRC_OSC) begin
                        if (r_reg.timer + 12'h001 >= oscCyc) begin
                            r_next.user  = 1'b1;
                            r_next.state = ST_USER;
                        end
                    end else if (startTick) begin
                        r_next.startCnt = r_reg.startCnt + 6'h01;
                        if (r_reg.startCnt + 6'h01 == startLimit) begin
                            r_next.user  = 1'b1;
                            r_next.state = ST_USER;
                        end
                    end
                end
                ST_USER: begin
                    r_next.user = 1'b1;
                end
                ST_FAULT: begin
                    // error held until the host restarts
                    r_next.errDrive = 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_reg          <= '0;
            r_reg.state    <= ST_RESTART;
            r_reg.errDrive <= 1'b1;
            r_reg.cmpDrive <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // open-drain pins only ever pull low
    assign errorStatusNOut   = 1'b0;
    assign configCompleteOut = 1'b0;
    assign errorStatusNOeN   = ~r_reg.errDrive;
    assign configCompleteOeN = ~r_reg.cmpDrive;
    assign readyNotBusy      = r_reg.rdy;
    assign serialBit         = r_reg.serBit;
    assign serialValid       = r_reg.serValid;
    assign userMode          = r_reg.user;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence restartFall;
        $fell(r_reg.rstS2) ##0 (r_reg.state != ST_RESTART);
    endsequence

    restartCmp_a: assert property (restartFall |=> !configCompleteOeN)
        else $error("completion not pulled low on restart");
    restartErr_a: assert property (restartFall |=> !errorStatusNOeN)
        else $error("error status not pulled low on restart");
    errMinPulse_a: assert property ($rose(errorStatusNOeN)
        |-> $past(r_reg.timer) >= pulseMin)
        else $error("error status pulse too short");
    errRelease_a: assert property ((r_reg.state == ST_STATUS && r_reg.rstS2
        && r_reg.timer >= pulseMin) |=> errorStatusNOeN)
        else $error("error status not released");
    readyLow_a: assert property (sif.loadStb |=> !readyNotBusy ##1 sif.busy)
        else $error("ready stayed high after capture");
    readyRise_a: assert property ($rose(readyNotBusy) && $past(r_reg.state) == ST_LOAD
        |-> $past(sif.bitValid) && !$past(sif.busy))
        else $error("ready rose before last bit");
    startLg_a: assert property ($rose(userMode) && largeVariant
        && startupSource != SRC_OSC |-> r_reg.startCnt == START_LG_CLKS)
        else $error("large startup count wrong");
    startSm_a: assert property ($rose(userMode) && !largeVariant
        && startupSource != SRC_OSC |-> r_reg.startCnt == START_SM_CLKS)
        else $error("small startup count wrong");
    oscStart_a: assert property ($rose(userMode) && startupSource == SRC_OSC
        |-> r_reg.timer == oscCyc)
        else $error("oscillator startup time wrong");
    faultErr_a: assert property (frameError && r_reg.rstS2 && r_reg.state == ST_LOAD
        |=> !errorStatusNOeN ##1 !errorStatusNOeN)
        else $error("error not flagged on frame error");
endmodule

// File: design/psl_serializer.sv
`timescale 1ns/1ps
module psl_serializer
    import psl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    psl_ser_if.ser   sif
);
    typedef struct packed {
        logic [7:0] shift;
        logic [3:0] cnt;
        logic       bitOut;
        logic       bitValid;
    } psl_ser_s;

    psl_ser_s r_reg;
    psl_ser_s r_next;

    // ****************************************
    // shift one bit per falling config clock edge
    // ****************************************
    always_comb begin
        r_next = r_reg;
        r_next.bitValid = 1'b0;
        if (sif.clear) begin
            r_next.cnt = 4'h0;
        end else if (sif.loadStb) begin
            r_next.shift = sif.loadByte;
            r_next.cnt   = BITS_PER_BYTE;
        end else if (sif.fallStb && r_reg.cnt != 4'h0) begin
            r_next.bitOut   = r_reg.shift[7]; // msb first
            r_next.shift    = {r_reg.shift[6:0], 1'b0};
            r_next.cnt      = r_reg.cnt - 4'h1;
            r_next.bitValid = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign sif.bitOut   = r_reg.bitOut;
    assign sif.bitValid = r_reg.bitValid;
    assign sif.busy     = (r_reg.cnt != 4'h0);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    loadBusy_a: assert property (sif.loadStb && !sif.clear |=> sif.busy)
        else $error("serializer not busy after load");
    shiftFall_a: assert property (sif.bitValid |-> $past(sif.fallStb))
        else $error("bit shifted without falling edge");
endmodule

// File: verif/psl_host_model.sv
`timescale 1ns/1ps
module psl_host_model (
    output logic       restartN,
    output logic       cfgClk,
    output logic [7:0] cfgData
);
    // ****************************************
    // host side of the parallel load port
    // ****************************************
    // idle levels: restart released, clock parked low outside frames
    initial begin
        restartN = 1'b1;
        cfgClk   = 1'b0;
        cfgData  = 8'h00;
    end

    // restart pulse; caller picks a width no shorter than the variant minimum
    task automatic restart_pulse(input int lowNs);
        restartN = 1'b0;
        #(lowNs);
        restartN = 1'b1;
    endtask

    // one 125 ns period, rise then fall; stands still afterwards
    task automatic pulse_clk();
        #62.5 cfgClk = 1'b1;
        #62.5 cfgClk = 1'b0;
    endtask

    // byte on the first rise, then eight falls; data inverted once hold ends
    task automatic send_byte(input logic [7:0] b);
        cfgData = b;
        for (int i = 0; i < 8; i++) begin
            pulse_clk();
            cfgData = ~b;
        end
    endtask

    // trailing clocks after the last byte for startup
    task automatic clocks(input int n);
        repeat (n) pulse_clk();
    endtask
endmodule

// File: verif/test_parallel_sync_config_load.sv
`timescale 1ns/1ps
module test_parallel_sync_config_load;
    import psl_pkg::*;
    logic        clk_sys, rst, usrClk, largeVariant, frameError, errHold;
    logic        errOut, errOeN, compOut, compOeN, readyNotBusy;
    logic        serialBit, serialValid, userMode;
    logic [1:0]  startupSource;
    logic [23:0] imageBytes;
    wire         restartN, cfgClk;
    wire  [7:0]  cfgData;
    logic        bitQ[$];
    int          errorCnt, checksDone;

    psl_host_model u_host (.restartN(restartN), .cfgClk(cfgClk), .cfgData(cfgData));

    // open-drain lines with pull-up; the host may also hold the error line low
    psl_config_load u_dut (
        .clk_sys(clk_sys), .rst(rst), .configRestartN(restartN), .configClock(cfgClk),
        .configData(cfgData), .userStartupClock(usrClk), .startupSource(startupSource),
        .largeVariant(largeVariant), .imageBytes(imageBytes), .frameError(frameError),
        .errorStatusNIn(errOeN & ~errHold), .errorStatusNOut(errOut), .errorStatusNOeN(errOeN),
        .configCompleteIn(compOeN), .configCompleteOut(compOut),
        .configCompleteOeN(compOeN), .readyNotBusy(readyNotBusy), .serialBit(serialBit),
        .serialValid(serialValid), .userMode(userMode));

    // ****************************************
    // clock, bit capture, helpers
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // collect serialized bits in emission order
    // mid-cycle sampling keeps clear of the edge that launches the pulse
    always @(negedge clk_sys) if (serialValid === 1'b1) bitQ.push_back(serialBit);

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (e !== g) begin
            errorCnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic chk_win(input string nm, input int lo, input int hi, input int g);
        checksDone++;
        if (g < lo || g > hi) begin
            errorCnt++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    // bounded wait so a stuck output shows as a count overrun
    task automatic cnt_until(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 20000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    task automatic usr_clocks(input int n);
        repeat (n) begin
            #50 usrClk = 1'b1;
            #50 usrClk = 1'b0;
        end
    endtask

    // restart handshake; host then waits out its own minimum delays
    task automatic begin_cfg(input logic lg, input logic [1:0] src, input int holdCyc);
        int lowCyc, n, m;
        @(posedge clk_sys);
        #1;
        largeVariant = lg;
        startupSource = src;
        errHold = (holdCyc > 0);
        bitQ.delete();
        lowCyc = lg ? 1250 : 250;
        fork u_host.restart_pulse(lowCyc * 8); join_none
        cnt_until(errOeN, 1'b0, n);
        chk_win("error low delay", 0, 25, n);
        chk("completion low", 1'b0, compOeN);
        chk("open-drain levels", 2'b00, {errOut, compOut});
        cnt_until(errOeN, 1'b1, m);
        chk_win("error release", lowCyc, lowCyc + (lg ? 125 : 500), n + m);
        // host stretches the error line; the device must keep waiting
        if (holdCyc > 0) begin
            repeat (holdCyc) @(posedge clk_sys);
            #1;
            chk("ready while held", 1'b0, readyNotBusy);
            errHold = 1'b0;
        end
        repeat (lg ? 5000 : 625) @(posedge clk_sys);
        #1;
        chk("ready before load", 1'b1, readyNotBusy);
    endtask

    // two bytes, ready timing on the first, bit order on both
    task automatic load(input logic [7:0] b0, input logic [7:0] b1);
        realtime t0;
        logic [15:0] got;
        int n;
        fork
            u_host.send_byte(b0);
            begin
                @(posedge cfgClk);
                t0 = $realtime;
                @(negedge readyNotBusy);
                @(posedge readyNotBusy);
                chk_win("ready rise ns", 938, 1010, int'($realtime - t0));
            end
        join
        u_host.send_byte(b1);
        cnt_until(compOeN, 1'b1, n);
        chk_win("completion release", 0, 16, n);
        foreach (bitQ[i]) got = {got[14:0], bitQ[i]};
        chk("bit count", 16, bitQ.size());
        chk("serial bits", {b0, b1}, got);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_cfgclk_small();
        begin_cfg(1'b0, 2'h2, 0);
        load(8'ha5, 8'h3c);
        repeat (4) @(posedge clk_sys);
        u_host.clocks(9);
        repeat (8) @(posedge clk_sys);
        chk("user mode early", 1'b0, userMode);
        u_host.clocks(1);
        repeat (8) @(posedge clk_sys);
        chk("user mode on time", 1'b1, userMode);
    endtask

    task automatic t_user_large();
        begin_cfg(1'b1, 2'h1, 0);
        load(8'h0f, 8'hf0);
        repeat (4) @(posedge clk_sys);
        usr_clocks(39);
        repeat (8) @(posedge clk_sys);
        chk("user mode early", 1'b0, userMode);
        usr_clocks(1);
        repeat (8) @(posedge clk_sys);
        chk("user mode on time", 1'b1, userMode);
    endtask

    task automatic t_osc_small();
        int n;
        begin_cfg(1'b0, 2'h0, 200);
        load(8'h81, 8'h7e);
        cnt_until(userMode, 1'b1, n);
        chk_win("osc startup cycles", 75, 250, n);
    endtask

    // a downstream error in mid-byte pulls the error line and holds it
    task automatic t_frame_error();
        begin_cfg(1'b0, 2'h2, 0);
        fork
            u_host.send_byte(8'h55);
            begin
                repeat (20) @(posedge clk_sys);
                #1 frameError = 1'b1;
                repeat (2) @(posedge clk_sys);
                #1 frameError = 1'b0;
                chk("error on fault", 1'b0, errOeN);
            end
        join
        chk("error held", 1'b0, errOeN);
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic complete_run();
        if (errorCnt == 0 && checksDone > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // watchdog well above the roughly 100 us the scenarios need
    initial begin
        #400us;
        errorCnt++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        usrClk = 1'b0;
        largeVariant = 1'b0;
        frameError = 1'b0;
        errHold = 1'b0;
        startupSource = 2'h2;
        imageBytes = 24'h000002;
        repeat (4) @(posedge clk_sys);
        #1 rst = 1'b0;
        chk("reset ready", 1'b0, readyNotBusy);
        t_cfgclk_small();
        t_user_large();
        t_osc_small();
        t_frame_error();
        complete_run();
    end
endmodule
